// ### hdl/pvic_cfg_regs.sv
// Configuration command bank of the converter: set point path, limits, input gating, phase spread.
// Assumes a bus layer that hands over decoded commands and measurements on the same clock.
// What this block does
// (RL1) Hold margin-down target, regulate to it.
// (RL2) Slew output at programmed volts per millisecond.
// (RL3) Lower set point by slope times current.
// (RL4) Never regulate below the output floor.
// (RL5) Request below floor warns, never faults.
// (RL6) Cap duty cycle at programmed percentage.
// (RL7) Switching frequency set in whole kilohertz.
// (RL8) Start converting when input reaches turn-on.
// (RL9) Stop converting when input falls to turn-off.
// (RL10) Bits 11:8 hold group identifier.
// (RL11) Bits 7:4 count units, clock source included.
// (RL12) Bits 3:0 give phase position; source zero.
// (RL13) Interleaved units share one phase reference, kept outside this block.
// (RL14) Add current offset to current readings.
// (RL15) Compare output against overvoltage fault threshold.
// (RL16) Mode byte is checked for linear format, exponent -11; any other flags a mode error and holds the ramp.
// (RL17) Linear words: five-bit exponent, eleven-bit mantissa.
`timescale 1ns/1ps
module pvic_cfg_regs
   import pvic_pkg::*;
#(
   parameter int CYC_PER_MS = PVIC_CYC_PER_MS       // Clock cycles per millisecond.
) (
   input  wire logic        clock_i,                // Control clock, 125 MHz.
   input  wire logic        rst_b_i,                // Asynchronous reset, active low.
   input  pvic_cmd_t        cmd_i,                  // Decoded command from the bus layer.
   output pvic_rsp_t        rsp_o,                  // Registered command answer.
   input  wire logic [7:0]  vout_mode_i,            // Output mode byte.
   input  wire logic        margin_low_i,           // Margin-low operation commanded.
   input  wire logic [15:0] vout_nominal_i,         // Nominal plus trim request.
   input  wire logic [15:0] vout_meas_i,            // Measured output, exponent -11.
   input  wire logic [15:0] vin_meas_i,             // Measured input, linear format.
   input  wire logic [15:0] iout_raw_i,             // Raw current reading, linear format.
   input  wire logic [15:0] duty_req_i,             // Requested duty, percent, 8 fraction bits.
   output logic [15:0]      vout_setpoint_o,        // Regulation set point, exponent -11.
   output logic             vout_low_warn_o,        // Request below floor.
   output logic             ov_fault_o,             // Output above fault threshold.
   output logic             mode_error_o,           // Mode byte not usable.
   output logic             conv_enable_o,          // Power conversion running.
   output logic [15:0]      duty_o,                 // Capped duty.
   output logic [15:0]      freq_khz_o,             // Switching frequency in kHz.
   output logic [3:0]       group_id_o,             // Interleave group.
   output logic [3:0]       rail_count_o,           // Units in the group.
   output logic [3:0]       rail_pos_o,             // This unit's position.
   output logic [7:0]       phase_frac_o,           // Phase offset in 1/256 periods.
   output logic [31:0]      iout_reading_o          // Corrected current, 8 fraction bits.
);

   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic [1:0] rst_sync;                            // Release synchroniser.
   logic       rst_n;                               // Synchronised reset.

   // Release passes two flops so no flop sees a ragged deassertion.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // -----------------------------------------------------------------
   // Command registers
   // -----------------------------------------------------------------
   logic [15:0] regs [PVIC_NREG];                   // Stored command words.
   logic [15:0] next_regs [PVIC_NREG];              // Next stored words.
   pvic_rsp_t   rsp, next_rsp;                      // Answer register.
   int          hit;                                // Matching slot, -1 if none.

   // Every command answers in the next cycle; an unknown code is refused.
   always_comb begin
      next_regs = regs;
      next_rsp  = '0;
      hit       = -1;
      for (int i = 0; i < PVIC_NREG; i++) begin
         if (cmd_i.code == PVIC_CODE[i]) hit = i;
      end
      if (cmd_i.valid) begin
         if (hit < 0) begin
            next_rsp.nack = 1'b1;
         end else begin
            next_rsp.ack = 1'b1;
            if (cmd_i.write) begin
               next_regs[hit] = cmd_i.data;                    // see (RL1)
            end else begin
               next_rsp.data = regs[hit];
            end
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PVIC_NREG; i++) regs[i] <= PVIC_RST[i];
         rsp <= '0;
      end else begin
         regs <= next_regs;
         rsp  <= next_rsp;
      end
   end
   assign rsp_o = rsp;

   // -----------------------------------------------------------------
   // Linear-format decoders
   // -----------------------------------------------------------------
   logic [15:0]        dec_in [PVIC_NDEC];          // Words to decode.
   logic signed [31:0] dec_q  [PVIC_NDEC];          // Decoded values.

   assign dec_in = '{regs[IX_RATE], regs[IX_SLOPE], regs[IX_DUTY], regs[IX_FREQ], regs[IX_VON],
                     regs[IX_VOFF], vin_meas_i, regs[IX_IOFF], iout_raw_i};

   for (genvar g = 0; g < PVIC_NDEC; g++) begin : g_dec
      pvic_lin_dec #(.FRAC(PVIC_FRAC[g]), .OW(32)) u_dec (
         .clock_i (clock_i),
         .rst_n_i (rst_n),
         .word_i  (dec_in[g]),
         .value_o (dec_q[g])
      );
   end

   // -----------------------------------------------------------------
   // Target selection and floor
   // -----------------------------------------------------------------
   logic        mode_ok_c;                          // Linear mode, exponent -11.
   logic [15:0] req_c;                              // Requested output.
   logic [15:0] tgt_c;                              // Request after floor clamp.

   always_comb begin
      mode_ok_c = (vout_mode_i[7:5] == PVIC_MODE_LINEAR) &&
                  (vout_mode_i[4:0] == PVIC_VOUT_EXP);          // see (RL16)
      req_c = margin_low_i ? regs[IX_MARGIN] : vout_nominal_i;  // see (RL1)
      tgt_c = (req_c < regs[IX_FLOOR]) ? regs[IX_FLOOR] : req_c; // see (RL4)
   end

   // -----------------------------------------------------------------
   // Slew ramp
   // -----------------------------------------------------------------
   logic [15:0] sp, next_sp;                        // Ramped set point.
   logic [31:0] acc, next_acc;                      // Rate accumulator.
   logic [31:0] rate_c;                             // Rate clipped to one step per cycle.
   logic [31:0] sum_c;                              // Accumulator plus rate.

   // Rate is LSB per ms; one step falls due each time the sum passes a millisecond.
   // A rate of zero or below jumps straight to the target, as no slope is defined.
   always_comb begin
      next_sp  = sp;
      next_acc = acc;
      rate_c   = (dec_q[D_RATE] > signed'(CYC_PER_MS)) ? 32'(CYC_PER_MS) : 32'(dec_q[D_RATE]);
      sum_c    = acc + rate_c;
      if (!mode_ok_c) begin
         next_acc = acc;                                       // see (RL16)
      end else if (sp == tgt_c) begin
         next_acc = '0;
      end else if (dec_q[D_RATE] <= 0) begin
         next_sp = tgt_c;
      end else if (sum_c >= 32'(CYC_PER_MS)) begin
         next_acc = sum_c - 32'(CYC_PER_MS);                   // see (RL2)
         next_sp  = (sp < tgt_c) ? sp + 16'h0001 : sp - 16'h0001;
      end else begin
         next_acc = sum_c;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         sp  <= '0;
         acc <= '0;
      end else begin
         sp  <= next_sp;
         acc <= next_acc;
      end
   end

   // -----------------------------------------------------------------
   // Droop, limits and outputs
   // -----------------------------------------------------------------
   logic signed [31:0] iout_c;                      // Corrected current, q8.
   logic [11:0]        amps_c;                      // Whole amps, clipped.
   logic [47:0]        drop_c;                      // Droop in output LSBs.
   logic [15:0]        cap_c;                       // Duty ceiling.
   logic [15:0]        next_setpoint, next_duty, next_freq;
   logic [7:0]         next_phase;
   logic               next_warn, next_ov;

   // mV*256 times amps divided by 125 gives volts*2048, the set point LSB.
   always_comb begin
      iout_c = dec_q[D_IRAW] + dec_q[D_IOFF];                  // see (RL14)
      amps_c = (iout_c < 0) ? 12'h000 :
               (iout_c[31:20] != 12'h000) ? 12'hFFF : iout_c[19:8];
      // An exact constant divide keeps round loads giving round droop values.
      drop_c = (48'(pvic_sat16(dec_q[D_SLOPE])) * 48'(amps_c)) /
               48'(PVIC_DROOP_DIV);                            // see (RL3)
      if ((drop_c >= 48'(sp)) || ((48'(sp) - drop_c) < 48'(regs[IX_FLOOR]))) begin
         next_setpoint = regs[IX_FLOOR];                       // see (RL4)
      end else begin
         next_setpoint = sp - drop_c[15:0];
      end
      next_warn = req_c < regs[IX_FLOOR];                      // see (RL5)
      next_ov   = vout_meas_i > regs[IX_OVLIM];                // see (RL15)
      cap_c     = pvic_sat16(dec_q[D_DUTY]);
      next_duty = (duty_req_i > cap_c) ? cap_c : duty_req_i;   // see (RL6)
      next_freq = pvic_sat16(dec_q[D_FREQ]);                   // see (RL7)
      // Position zero is the clock source and runs with no offset.
      if (regs[IX_SPREAD][PVIC_POS_LSB +: 4] >= regs[IX_SPREAD][PVIC_CNT_LSB +: 4]) begin
         next_phase = 8'h00;
      end else begin
         next_phase = 8'({regs[IX_SPREAD][PVIC_POS_LSB +: 4], 8'h00} /
                         {8'h00, regs[IX_SPREAD][PVIC_CNT_LSB +: 4]}); // see (RL12)
      end
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         vout_setpoint_o <= '0;
         vout_low_warn_o <= 1'b0;
         ov_fault_o      <= 1'b0;
         mode_error_o    <= 1'b0;
         duty_o          <= '0;
         freq_khz_o      <= '0;
         phase_frac_o    <= '0;
         iout_reading_o  <= '0;
      end else begin
         vout_setpoint_o <= next_setpoint;
         vout_low_warn_o <= next_warn;
         ov_fault_o      <= next_ov;
         mode_error_o    <= !mode_ok_c;
         duty_o          <= next_duty;
         freq_khz_o      <= next_freq;
         phase_frac_o    <= next_phase;
         iout_reading_o  <= iout_c;
      end
   end

   // Fields come straight from the stored word.
   assign group_id_o   = regs[IX_SPREAD][PVIC_GID_LSB +: 4];   // see (RL10)
   assign rail_count_o = regs[IX_SPREAD][PVIC_CNT_LSB +: 4];   // see (RL11)
   assign rail_pos_o   = regs[IX_SPREAD][PVIC_POS_LSB +: 4];   // see (RL12)

   // -----------------------------------------------------------------
   // Input gating
   // -----------------------------------------------------------------
   pvic_conv_t conv, next_conv;                     // Conversion state.

   // Hysteresis between the two thresholds; the phase reference (RL13) is outside.
   always_comb begin
      case (conv)
         CONV_OFF: next_conv = (dec_q[D_VIN] >= dec_q[D_VON]) ? CONV_ON : CONV_OFF;  // see (RL8)
         CONV_ON:  next_conv = (dec_q[D_VIN] <= dec_q[D_VOFF]) ? CONV_OFF : CONV_ON; // see (RL9)
         default:  next_conv = CONV_OFF;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         conv <= CONV_OFF;
      end else begin
         conv <= next_conv;
      end
   end
   assign conv_enable_o = (conv == CONV_ON);

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n);

   property p_floor;
      ##1 vout_setpoint_o >= $past(regs[IX_FLOOR]);
   endproperty
   a_floor: assert property (p_floor) else $error("set point below floor"); // see (RL4)

   property p_warn;
      ##1 vout_low_warn_o == ($past(req_c) < $past(regs[IX_FLOOR]));
   endproperty
   a_warn: assert property (p_warn) else $error("floor warning wrong"); // see (RL5)

   property p_ov;
      ##1 ov_fault_o == ($past(vout_meas_i) > $past(regs[IX_OVLIM]));
   endproperty
   a_ov: assert property (p_ov) else $error("overvoltage flag wrong"); // see (RL15)

   property p_turn_on;
      $rose(conv_enable_o) |-> $past(dec_q[D_VIN] >= dec_q[D_VON]);
   endproperty
   a_turn_on: assert property (p_turn_on) else $error("started below turn-on"); // see (RL8)

   property p_turn_off;
      $fell(conv_enable_o) |-> $past(dec_q[D_VIN] <= dec_q[D_VOFF]);
   endproperty
   a_turn_off: assert property (p_turn_off) else $error("stopped above turn-off"); // see (RL9)

   property p_slew;
      (dec_q[D_RATE] > 0) && mode_ok_c |=> (sp == $past(sp)) || (sp == $past(sp) + 16'h0001) ||
                                          (sp == $past(sp) - 16'h0001);
   endproperty
   a_slew: assert property (p_slew) else $error("set point jumped"); // see (RL2)

   property p_margin;
      margin_low_i && mode_ok_c && (dec_q[D_RATE] <= 0) && (regs[IX_MARGIN] >= regs[IX_FLOOR])
      && $stable(regs[IX_MARGIN]) |=> sp == $past(regs[IX_MARGIN]);
   endproperty
   a_margin: assert property (p_margin) else $error("margin target missed"); // see (RL1)

   property p_duty;
      ##1 duty_o <= $past(cap_c);
   endproperty
   a_duty: assert property (p_duty) else $error("duty above ceiling"); // see (RL6)

   property p_mode_hold;
      !mode_ok_c |=> $stable(sp);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("ramp moved in bad mode"); // see (RL16)

   property p_phase;
      (rail_pos_o == 4'h0) |=> (phase_frac_o == 8'h00) || !$stable(regs[IX_SPREAD]);
   endproperty
   a_phase: assert property (p_phase) else $error("source unit offset"); // see (RL12)

   c_margin: cover property (margin_low_i ##1 $changed(sp));
   c_conv:   cover property ($rose(conv_enable_o) ##[1:100] $fell(conv_enable_o));
   c_warn:   cover property ($rose(vout_low_warn_o));
   c_nack:   cover property (rsp_o.nack);

endmodule // pvic_cfg_regs

// ### hdl/pvic_lin_dec.sv
// Registered decoder from a 16-bit linear-format word to signed fixed point.
// Assumes the synchronised reset of the top module.
`timescale 1ns/1ps
module pvic_lin_dec
   import pvic_pkg::*;
#(
   parameter int FRAC = 8,                          // Fraction bits of the result.
   parameter int OW   = 32                          // Result width.
) (
   input  wire logic                 clock_i,       // Control clock.
   input  wire logic                 rst_n_i,       // Synchronised reset, active low.
   input  wire logic [15:0]          word_i,        // Linear-format word.
   output logic signed [OW-1:0]      value_o        // Mantissa times 2^exp times 2^FRAC.
);

   logic signed [47:0]   mant_c;                    // Scaled mantissa.
   logic signed [47:0]   shift_c;                   // After the exponent.
   int                   exp_c;                     // Signed exponent.
   logic signed [OW-1:0] next_value;                // Next decoded value.

   // -----------------------------------------------------------------
   // Decode: five-bit exponent above an eleven-bit mantissa.
   // -----------------------------------------------------------------
   always_comb begin
      exp_c   = int'(signed'(word_i[15:11]));                  // see (RL17)
      mant_c  = 48'(signed'(word_i[10:0])) <<< FRAC;           // see (RL17)
      if (exp_c >= 0) begin
         shift_c = mant_c <<< exp_c;
      end else begin
         shift_c = mant_c >>> (-exp_c);
      end
      next_value = OW'(shift_c);
   end

   // Registered so that the long shifter is off the consumer's path.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_o <= '0;
      end else begin
         value_o <= next_value;
      end
   end

endmodule // pvic_lin_dec

// ### pkg/pvic_pkg.sv
// Shared constants and types for the converter configuration command bank.
// Assumes one 125 MHz control clock and a decoded command port from the bus layer.
package pvic_pkg;

   // -----------------------------------------------------------------
   // Command codes and register slots
   // -----------------------------------------------------------------
   localparam int PVIC_NREG = 11;                   // Number of command registers.
   localparam int IX_MARGIN = 0;                    // Margin-down target slot.
   localparam int IX_RATE   = 1;                    // Output slew rate slot.
   localparam int IX_SLOPE  = 2;                    // Load-line slope slot.
   localparam int IX_FLOOR  = 3;                    // Output floor slot.
   localparam int IX_DUTY   = 4;                    // Duty ceiling slot.
   localparam int IX_FREQ   = 5;                    // Switching rate slot.
   localparam int IX_VON    = 6;                    // Input turn-on slot.
   localparam int IX_VOFF   = 7;                    // Input turn-off slot.
   localparam int IX_SPREAD = 8;                    // Phase spread slot.
   localparam int IX_IOFF   = 9;                    // Current offset slot.
   localparam int IX_OVLIM  = 10;                   // Overvoltage threshold slot.
   localparam logic [7:0] PVIC_CODE [PVIC_NREG] = '{8'h26, 8'h27, 8'h28, 8'h2B, 8'h32, 8'h33,
                                                    8'h35, 8'h36, 8'h37, 8'h39, 8'h40};
   localparam logic [15:0] PVIC_RST [PVIC_NREG] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                                    16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                                    16'h0010, 16'h0000, 16'hFFFF};

   // -----------------------------------------------------------------
   // Field positions and mode byte
   // -----------------------------------------------------------------
   localparam int PVIC_GID_LSB = 8;                 // Group identifier field.
   localparam int PVIC_CNT_LSB = 4;                 // Unit count field.
   localparam int PVIC_POS_LSB = 0;                 // Interleave position field.
   localparam logic [2:0] PVIC_MODE_LINEAR = 3'h0;  // Mode bits 7:5 for linear.
   localparam logic [4:0] PVIC_VOUT_EXP    = 5'h15; // Exponent -11 in two's complement.

   // -----------------------------------------------------------------
   // Linear-format decoder slots and fraction bits
   // -----------------------------------------------------------------
   localparam int PVIC_NDEC = 9;                    // Number of decoders.
   localparam int D_RATE = 0;                       // Rate in LSB per ms.
   localparam int D_SLOPE = 1;                      // Slope in mV/A, 8 fraction bits.
   localparam int D_DUTY = 2;                       // Duty percent, 8 fraction bits.
   localparam int D_FREQ = 3;                       // Frequency in whole kHz.
   localparam int D_VON = 4;                        // Turn-on volts, 8 fraction bits.
   localparam int D_VOFF = 5;                       // Turn-off volts, 8 fraction bits.
   localparam int D_VIN = 6;                        // Measured input volts.
   localparam int D_IOFF = 7;                       // Current offset amps.
   localparam int D_IRAW = 8;                       // Raw current amps.
   localparam int PVIC_FRAC [PVIC_NDEC] = '{11, 8, 8, 0, 8, 8, 8, 8, 8};

   // -----------------------------------------------------------------
   // Timing and arithmetic constants
   // -----------------------------------------------------------------
   localparam int PVIC_CLK_NS = 8;                  // Clock period in ns.
   localparam int PVIC_MS_NS = 1000000;             // One millisecond in ns.
   localparam int PVIC_CYC_PER_MS = PVIC_MS_NS / PVIC_CLK_NS;
   localparam int PVIC_DROOP_DIV = 125;             // mV*256 times amps over this is volts*2048.

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        valid;                           // One-cycle command strobe.
      logic        write;                           // High for write word.
      logic [7:0]  code;                            // Command code.
      logic [15:0] data;                            // Write data.
   } pvic_cmd_t;

   typedef struct packed {
      logic        ack;                             // Command accepted.
      logic        nack;                            // Unknown command code.
      logic [15:0] data;                            // Read data.
   } pvic_rsp_t;

   typedef enum logic [1:0] {
      CONV_OFF = 2'b01,
      CONV_ON  = 2'b10
   } pvic_conv_t;

   // Clamps a signed value into an unsigned 16-bit field.
   function automatic logic [15:0] pvic_sat16(input logic signed [31:0] v);
      if (v < 0) return 16'h0000;
      if (v > 32'sh0000FFFF) return 16'hFFFF;
      return v[15:0];
   endfunction

endpackage

// ### test/pvic_host.sv
// Host model that issues one command word at a time.
// Assumes the answer stands one cycle after the command edge.
`timescale 1ns/1ps
module pvic_host
   import pvic_pkg::*;
(
   input  wire logic clock_i, // Control clock.
   output pvic_cmd_t cmd_o,   // Command toward the bank.
   input  pvic_rsp_t rsp_i    // Answer from the bank.
);
   initial cmd_o = '0;
   // One strobe cycle, then the answer is taken while it stands.
   task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, output pvic_rsp_t r);
      @(posedge clock_i);
      cmd_o <= '{valid: 1'b1, write: w, code: c, data: d};
      @(posedge clock_i);
      cmd_o <= '0;
      #1 r = rsp_i;
   endtask
endmodule // pvic_host

// ### test/test_pvic_cfg_regs.sv
// Self-checking bench for the configuration command bank.
// Assumes the host model drives the command port.
`timescale 1ns/1ps
module test_pvic_cfg_regs;
   import pvic_pkg::*;
   logic clock_i = 0, rst_b_i = 0, ml = 0;
   logic [7:0] mode = 8'h15;
   // Input starts at -1 V so that a zero turn-on level after reset cannot start conversion.
   logic [15:0] nom = 16'h1000, vm = 16'h0000, vin = 16'h07FF, ir = 16'h000A, dq = 16'h4000;
   pvic_cmd_t cmd;
   pvic_rsp_t rsp, r;
   logic [15:0] sp, duty, fk;
   logic w, ov, me, ce;
   logic [3:0] g, c, p;
   logic [7:0] ph;
   logic [31:0] io;
   int err_total = 0, n_tests = 0;
   typedef struct {logic [7:0] code; logic [15:0] wd; logic nk; logic [15:0] rd;} pvic_row_t;
   // Writes then reads back; the two unmapped codes must be refused.
   // Spread 0A31 puts this unit at place 1 of 3, behind a source at place 0 on the shared phase clock.
   pvic_row_t rows [13] = '{'{8'h26, 16'h3000, 0, 16'h3000}, '{8'h27, 16'h0000, 0, 16'h0000},
      '{8'h28, 16'h0000, 0, 16'h0000}, '{8'h2B, 16'h2000, 0, 16'h2000}, '{8'h32, 16'h0032, 0, 16'h0032},
      '{8'h33, 16'h00FA, 0, 16'h00FA}, '{8'h35, 16'h0028, 0, 16'h0028}, '{8'h36, 16'h0023, 0, 16'h0023},
      '{8'h37, 16'h0A31, 0, 16'h0A31}, '{8'h39, 16'h0002, 0, 16'h0002}, '{8'h40, 16'h3000, 0, 16'h3000},
      '{8'h29, 16'h1234, 1, 16'h0000}, '{8'h2A, 16'hFFFF, 1, 16'h0000}};
   always #4 clock_i = ~clock_i;
   pvic_host u_host (.clock_i(clock_i), .cmd_o(cmd), .rsp_i(rsp));
   pvic_cfg_regs #(.CYC_PER_MS(100)) u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cmd_i(cmd), .rsp_o(rsp),
      .vout_mode_i(mode), .margin_low_i(ml), .vout_nominal_i(nom), .vout_meas_i(vm), .vin_meas_i(vin),
      .iout_raw_i(ir), .duty_req_i(dq), .vout_setpoint_o(sp), .vout_low_warn_o(w), .ov_fault_o(ov),
      .mode_error_o(me), .conv_enable_o(ce), .duty_o(duty), .freq_khz_o(fk), .group_id_o(g),
      .rail_count_o(c), .rail_pos_o(p), .phase_frac_o(ph), .iout_reading_o(io));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task automatic settle();
      repeat (8) @(posedge clock_i);
      #1;
   endtask
   task automatic complete_run();
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hung handshakes are cut short well after the expected run.
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      u_host.xfer(0, 8'h37, 0, r);
      chk(r.data, 16'h0010);
      chk(ce, 0);
      foreach (rows[i]) begin
         u_host.xfer(1, rows[i].code, rows[i].wd, r);
         chk(r.nack, rows[i].nk);
         u_host.xfer(0, rows[i].code, 0, r);
         chk({r.ack, r.data}, {~rows[i].nk, rows[i].rd});
      end
      settle();
      chk({sp, w}, {16'h2000, 1'b1});
      chk({ov, me}, 0);
      chk(duty, 16'h3200);
      chk(fk, 16'h00FA);
      chk({g, c, p, ph}, 20'hA3155);
      chk(io, 32'h0C00);
      @(posedge clock_i);
      ml <= 1'b1;
      vm <= 16'h3001;
      vin <= 16'h0030;
      settle();
      chk({sp, w, ov, ce}, {16'h3000, 3'b011});
      @(posedge clock_i);
      vin <= 16'h0024;
      settle();
      chk(ce, 1);
      @(posedge clock_i);
      vin <= 16'h0023;
      mode <= 8'h35;
      settle();
      chk({ce, me}, 2'b01);
      // Ten LSB per ms against 100 cycles per ms: one step every ten cycles, four steps in all.
      @(posedge clock_i);
      mode <= 8'h15;
      u_host.xfer(1, 8'h27, 16'hA80A, r);
      u_host.xfer(1, 8'h26, 16'h3004, r);
      settle();
      chk(sp, 16'h3000);
      repeat (2) settle();
      chk(sp, 16'h3002);
      repeat (3) settle();
      chk(sp, 16'h3004);
      // At 12 A, 125 mV/A drops 1.5 V (0C00 LSB); 250 mV/A would cross the floor.
      u_host.xfer(1, 8'h28, 16'h007D, r);
      settle();
      chk(sp, 16'h2404);
      u_host.xfer(1, 8'h28, 16'h00FA, r);
      settle();
      chk(sp, 16'h2000);
      // A reset in mid-run brings the registers back to their values after reset.
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      u_host.xfer(0, 8'h40, 0, r);
      chk({r.ack, r.data}, {1'b1, 16'hFFFF});
      chk(sp, 16'h0000);
      complete_run();
   end
endmodule // test_pvic_cfg_regs
